/* rtl/blg_defines.svh */
// Constants for the byte load group: selectors, opcode fields, prefixes and machine-cycle lengths.
`ifndef BLG_DEFINES_SVH
`define BLG_DEFINES_SVH
`define BLG_SEL_A        3'h7
`define BLG_SEL_B        3'h0
`define BLG_SEL_C        3'h1
`define BLG_SEL_D        3'h2
`define BLG_SEL_E        3'h3
`define BLG_SEL_H        3'h4
`define BLG_SEL_L        3'h5
`define BLG_SEL_MEM      3'h6
`define BLG_PFX_ONE      8'hdd
`define BLG_PFX_TWO      8'hfd
`define BLG_GRP_COPY     2'h1
`define BLG_GRP_IMM      2'h0
`define BLG_IMM_LOW      3'h6
`define BLG_STORE_HI     5'h0e
`define BLG_T_FETCH      3'h4
`define BLG_T_MEM        3'h3
`define BLG_T_CALC       3'h5
`define BLG_RST_BYTE     8'h00
`define BLG_RST_WORD     16'h0000
`endif

/* rtl/blg_pkg.sv */
// Types shared by the byte load group logic.
package blg_pkg;
  typedef enum logic [2:0] {
    BLG_IDLE  = 3'b000,
    BLG_OP    = 3'b001,
    BLG_DISP  = 3'b010,
    BLG_CALC  = 3'b011,
    BLG_MRD   = 3'b100,
    BLG_MWR   = 3'b101,
    BLG_IMM   = 3'b110
  } blg_state_t;
  typedef enum logic [2:0] {
    BLG_K_NONE  = 3'b000,
    BLG_K_COPY  = 3'b001,
    BLG_K_IMM   = 3'b010,
    BLG_K_LDPTR = 3'b011,
    BLG_K_STPTR = 3'b100,
    BLG_K_LDIDX = 3'b101
  } blg_kind_t;
endpackage : blg_pkg

/* rtl/blg_tcount.sv */
// Counts the clock periods of one machine cycle and flags its last period.
`include "blg_defines.svh"
module blg_tcount (
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_start,
  input  wire logic [2:0] i_len,
  output logic            o_last
);
  logic [2:0] count;
  logic [2:0] len;
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      count <= 3'h0;
      len   <= 3'h0;
    end else if (i_start) begin
      count <= 3'h1;
      len   <= i_len;
    end else if (count != 3'h0 && count != len) begin
      count <= count + 3'h1;
    end else begin
      count <= 3'h0;
    end
  end
  assign o_last = (count != 3'h0) && (count == len);
endmodule : blg_tcount

/* rtl/blg_exec.sv */
// Decode and execution of the 8-bit byte load group.
`include "blg_defines.svh"
module blg_exec
  import blg_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_start,
  input  wire logic [7:0]  i_mem_rdata,
  output logic [ADDR_W-1:0] o_mem_addr,
  output logic [7:0]       o_mem_wdata,
  output logic             o_mem_rd,
  output logic             o_mem_wr,
  output logic             o_busy,
  output logic             o_done,
  output logic [7:0]       o_flags,
  output logic [7:0]       o_reg_a,
  output logic [7:0]       o_reg_b,
  output logic [7:0]       o_reg_c,
  output logic [7:0]       o_reg_d,
  output logic [7:0]       o_reg_e,
  output logic [7:0]       o_reg_h,
  output logic [7:0]       o_reg_l,
  output logic [15:0]      o_index_reg_one,
  output logic [15:0]      o_index_reg_two
);
  if (ADDR_W != 16) begin : g_bad_width
    $error("blg_exec serves only a 16-bit address");
  end

  blg_state_t  state;
  blg_kind_t   kind;
  logic [7:0]  regs [0:7];
  logic [7:0]  opcode;
  logic [2:0]  sel_dst;
  logic [2:0]  sel_src;
  logic        use_two;
  logic [15:0] addr;
  logic        cyc_start;
  logic [2:0]  cyc_len;
  logic        cyc_last;
  logic [15:0] index_reg_one;
  logic [15:0] index_reg_two;
  logic [7:0]  flags;

  // Maps a selector to its storage slot; slot 6 is the memory operand and holds nothing.
  function automatic logic [2:0] sel_slot(input logic [2:0] sel);
    case (sel)
      `BLG_SEL_A: sel_slot = 3'h7;
      `BLG_SEL_B: sel_slot = 3'h0;
      `BLG_SEL_C: sel_slot = 3'h1;
      `BLG_SEL_D: sel_slot = 3'h2;
      `BLG_SEL_E: sel_slot = 3'h3;
      `BLG_SEL_H: sel_slot = 3'h4;
      `BLG_SEL_L: sel_slot = 3'h5;
      default:    sel_slot = 3'h6;
    endcase
  endfunction : sel_slot

  // Classifies an unprefixed or prefixed opcode byte.
  function automatic blg_kind_t classify(input logic [7:0] op, input logic pfx);
    if (pfx) begin
      classify = (op[7:6] == `BLG_GRP_COPY && op[2:0] == `BLG_SEL_MEM && op[5:3] != `BLG_SEL_MEM)
                 ? BLG_K_LDIDX : BLG_K_NONE;
    end else if (op[7:3] == `BLG_STORE_HI && op[2:0] != `BLG_SEL_MEM) begin
      classify = BLG_K_STPTR;
    end else if (op[7:6] == `BLG_GRP_COPY && op[5:3] != `BLG_SEL_MEM) begin
      classify = (op[2:0] == `BLG_SEL_MEM) ? BLG_K_LDPTR : BLG_K_COPY;
    end else if (op[7:6] == `BLG_GRP_IMM && op[2:0] == `BLG_IMM_LOW && op[5:3] != `BLG_SEL_MEM) begin
      classify = BLG_K_IMM;
    end else begin
      classify = BLG_K_NONE;
    end
  endfunction : classify

  blg_tcount u_tcount (
    .i_sys_clk (i_sys_clk),
    .i_reset_n (i_reset_n),
    .i_start   (cyc_start),
    .i_len     (cyc_len),
    .o_last    (cyc_last)
  );

  // The state machine picks each cycle's length as it enters it.
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state     <= BLG_IDLE;
      kind      <= BLG_K_NONE;
      opcode    <= `BLG_RST_BYTE;
      use_two   <= 1'b0;
      cyc_start <= 1'b0;
      cyc_len   <= `BLG_T_FETCH;
      addr      <= `BLG_RST_WORD;
      o_done    <= 1'b0;
      o_busy    <= 1'b0;
    end else begin
      cyc_start <= 1'b0;
      o_done    <= 1'b0;
      case (state)
        BLG_IDLE: begin
          if (i_start) begin
            o_busy    <= 1'b1;
            state     <= BLG_OP;
            cyc_start <= 1'b1;
            cyc_len   <= `BLG_T_FETCH;
            addr      <= {regs[4], regs[5]};
          end
        end
        BLG_OP: begin
          if (cyc_last) begin
            if (i_mem_rdata == `BLG_PFX_ONE || i_mem_rdata == `BLG_PFX_TWO) begin
              use_two   <= (i_mem_rdata == `BLG_PFX_TWO);
              state     <= BLG_DISP;
              cyc_start <= 1'b1;
              cyc_len   <= `BLG_T_FETCH;
            end else begin
              opcode <= i_mem_rdata;
              kind   <= classify(i_mem_rdata, 1'b0);
              case (classify(i_mem_rdata, 1'b0))
                BLG_K_IMM: begin
                  state     <= BLG_IMM;
                  cyc_start <= 1'b1;
                  cyc_len   <= `BLG_T_MEM;
                end
                BLG_K_LDPTR: begin
                  state     <= BLG_MRD;
                  cyc_start <= 1'b1;
                  cyc_len   <= `BLG_T_MEM;
                end
                BLG_K_STPTR: begin
                  state     <= BLG_MWR;
                  cyc_start <= 1'b1;
                  cyc_len   <= `BLG_T_MEM;
                end
                default: begin
                  state  <= BLG_IDLE;
                  o_busy <= 1'b0;
                  o_done <= 1'b1;
                end
              endcase
            end
          end
        end
        BLG_DISP: begin
          if (cyc_last) begin
            if (opcode == `BLG_RST_BYTE) begin
              opcode <= i_mem_rdata;
              kind   <= classify(i_mem_rdata, 1'b1);
              if (classify(i_mem_rdata, 1'b1) == BLG_K_LDIDX) begin
                cyc_start <= 1'b1;
                cyc_len   <= `BLG_T_MEM;
              end else begin
                state  <= BLG_IDLE;
                o_busy <= 1'b0;
                o_done <= 1'b1;
              end
            end else begin
              addr      <= (use_two ? index_reg_two : index_reg_one)
                           + {{8{i_mem_rdata[7]}}, i_mem_rdata};
              state     <= BLG_CALC;
              cyc_start <= 1'b1;
              cyc_len   <= `BLG_T_CALC;
            end
          end
        end
        BLG_CALC: begin
          if (cyc_last) begin
            state     <= BLG_MRD;
            cyc_start <= 1'b1;
            cyc_len   <= `BLG_T_MEM;
          end
        end
        BLG_IMM, BLG_MRD, BLG_MWR: begin
          if (cyc_last) begin
            state  <= BLG_IDLE;
            opcode <= `BLG_RST_BYTE;
            o_busy <= 1'b0;
            o_done <= 1'b1;
          end
        end
        default: begin
          state <= BLG_IDLE;
        end
      endcase
      if (state == BLG_IDLE) begin
        opcode <= `BLG_RST_BYTE;
      end
    end
  end

  // Bus strobes; only the memory read and write cycles drive a strobe and the address, the opcode and operand fetches drive neither.
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_mem_addr  <= `BLG_RST_WORD;
      o_mem_wdata <= `BLG_RST_BYTE;
      o_mem_rd    <= 1'b0;
      o_mem_wr    <= 1'b0;
    end else begin
      o_mem_rd <= (state == BLG_MRD) && !cyc_last;
      o_mem_wr <= (state == BLG_MWR) && !cyc_last;
      o_mem_addr <= (state == BLG_MRD || state == BLG_MWR) ? addr : o_mem_addr;
      if (state == BLG_MWR) begin
        o_mem_wdata <= regs[sel_src];
      end
    end
  end

  assign sel_dst = sel_slot(opcode[5:3]);
  assign sel_src = sel_slot(opcode[2:0]);

  // Register file writes; copies complete at the end of the fetch cycle.
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < 8; i++) begin
        regs[i] <= `BLG_RST_BYTE;
      end
    end else if (state == BLG_OP && cyc_last && classify(i_mem_rdata, 1'b0) == BLG_K_COPY) begin
      regs[sel_slot(i_mem_rdata[5:3])] <= regs[sel_slot(i_mem_rdata[2:0])];
    end else if (cyc_last && (state == BLG_IMM || state == BLG_MRD)) begin
      regs[sel_dst] <= i_mem_rdata;
    end
  end

  // Index registers are held here; no instruction of this group changes them.
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      index_reg_one <= `BLG_RST_WORD;
      index_reg_two <= `BLG_RST_WORD;
      flags         <= `BLG_RST_BYTE;
    end else begin
      flags <= flags;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_reg_a <= `BLG_RST_BYTE;
      o_reg_b <= `BLG_RST_BYTE;
      o_reg_c <= `BLG_RST_BYTE;
      o_reg_d <= `BLG_RST_BYTE;
      o_reg_e <= `BLG_RST_BYTE;
      o_reg_h <= `BLG_RST_BYTE;
      o_reg_l <= `BLG_RST_BYTE;
      o_flags <= `BLG_RST_BYTE;
      o_index_reg_one <= `BLG_RST_WORD;
      o_index_reg_two <= `BLG_RST_WORD;
    end else begin
      o_reg_a <= regs[7];
      o_reg_b <= regs[0];
      o_reg_c <= regs[1];
      o_reg_d <= regs[2];
      o_reg_e <= regs[3];
      o_reg_h <= regs[4];
      o_reg_l <= regs[5];
      o_flags <= flags;
      o_index_reg_one <= index_reg_one;
      o_index_reg_two <= index_reg_two;
    end
  end

  // A write strobe never appears outside a store cycle.
  a_store_only: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    o_mem_wr |-> $past(state) == BLG_MWR)
    else $error("write strobe outside a store cycle");
  // The flag byte is constant.
  a_flags_hold: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    ##1 o_flags == $past(o_flags))
    else $error("flags changed during a load");
  // A fetch cycle lasts four periods.
  sequence s_fetch_begin;
    cyc_start && cyc_len == `BLG_T_FETCH;
  endsequence
  a_fetch_len: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    s_fetch_begin |-> !cyc_last [*4] ##1 cyc_last)
    else $error("fetch cycle not four periods");
  // A memory cycle lasts three periods.
  a_mem_len: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (cyc_start && cyc_len == `BLG_T_MEM) |-> !cyc_last [*3] ##1 cyc_last)
    else $error("memory cycle not three periods");
  // The calculation cycle lasts five periods.
  a_calc_len: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (cyc_start && cyc_len == `BLG_T_CALC) |-> !cyc_last [*5] ##1 cyc_last)
    else $error("calculation cycle not five periods");
  // Done follows busy by exactly one release.
  a_done_busy: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    o_done |-> !o_busy && $past(o_busy))
    else $error("done without a finished instruction");
  // Only a load that takes its operand from memory may raise the read strobe.
  a_read_kind: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    o_mem_rd |-> (kind == BLG_K_LDPTR || kind == BLG_K_LDIDX))
    else $error("read strobe outside a memory load");
endmodule : blg_exec

/* verif/blg_mem_model.sv */
// Behavioural memory and fetch-byte source on the far side of the byte load group.
module blg_mem_model (
  input  wire logic        i_sys_clk,
  input  wire logic        i_mem_rd,
  input  wire logic        i_mem_wr,
  input  wire logic [15:0] i_mem_addr,
  input  wire logic [7:0]  i_mem_wdata,
  input  wire logic [7:0]  i_fetch,
  output logic [7:0]       o_mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:65535];
  // Outside a read cycle the bus shows the fetch stream, so a stale read byte can never pass for an operand.
  assign o_mem_rdata = i_mem_rd ? mem[i_mem_addr] : i_fetch;
  always @(posedge i_sys_clk) if (i_mem_wr) mem[i_mem_addr] = i_mem_wdata;
endmodule : blg_mem_model

/* verif/tb.sv */
// Self-checking testbench for the byte load group execution block.
`include "blg_defines.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_sys_clk = 1'b0;
  logic        i_reset_n = 1'b0;
  logic        i_start   = 1'b0;
  logic [7:0]  fetch     = 8'h00;
  logic [7:0]  i_mem_rdata, o_mem_wdata, o_flags;
  logic [7:0]  o_reg_a, o_reg_b, o_reg_c, o_reg_d, o_reg_e, o_reg_h, o_reg_l;
  logic [15:0] o_mem_addr, o_index_reg_one, o_index_reg_two;
  logic        o_mem_rd, o_mem_wr, o_busy, o_done;
  logic        done_d = 1'b0;
  logic [63:0] seen;
  logic [7:0]  rf [8];
  logic [63:0] exp_q [$];
  logic [23:0] wr_q [$];
  logic [15:0] rd_q [$];
  int          fail_count = 0, checks_done = 0, cyc = 0, rd_len = 0, wr_len = 0;
  int          sel [7] = '{7, 0, 1, 2, 3, 4, 5};

  always #20 i_sys_clk = ~i_sys_clk;
  assign seen = {o_reg_a, o_reg_b, o_reg_c, o_reg_d, o_reg_e, o_reg_h, o_reg_l, o_flags};

  blg_exec dut (
    .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_start(i_start), .i_mem_rdata(i_mem_rdata),
    .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr),
    .o_busy(o_busy), .o_done(o_done), .o_flags(o_flags), .o_reg_a(o_reg_a), .o_reg_b(o_reg_b),
    .o_reg_c(o_reg_c), .o_reg_d(o_reg_d), .o_reg_e(o_reg_e), .o_reg_h(o_reg_h), .o_reg_l(o_reg_l),
    .o_index_reg_one(o_index_reg_one), .o_index_reg_two(o_index_reg_two));

  blg_mem_model mdl (
    .i_sys_clk(i_sys_clk), .i_mem_rd(o_mem_rd), .i_mem_wr(o_mem_wr), .i_mem_addr(o_mem_addr),
    .i_mem_wdata(o_mem_wdata), .i_fetch(fetch), .o_mem_rdata(i_mem_rdata));

  task automatic close_out();
    if (fail_count == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out

  task automatic check(input string name, input logic [63:0] e, input logic [63:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, e, g);
    end
  endtask : check

  function automatic logic [63:0] pack_rf();
    return {rf[7], rf[0], rf[1], rf[2], rf[3], rf[4], rf[5], 8'h00};
  endfunction : pack_rf

  // Each byte stands until the edge that closes its machine cycle; the block spends one start period before
  // every cycle, hence the extra period. After the last byte the line shows the inverse so nothing stale lingers.
  task automatic run(input logic [7:0] b [4], input int ln [4], input int nb);
    int t;
    i_start = 1'b1;
    fetch = b[0];
    @(negedge i_sys_clk);
    i_start = 1'b0;
    for (int k = 0; k < nb; k++) begin
      repeat (ln[k] + 1) @(negedge i_sys_clk);
      fetch = (k + 1 < nb) ? b[k + 1] : ~fetch;
    end
    t = 0;
    while (o_busy !== 1'b0 && t < 200) begin
      @(negedge i_sys_clk);
      t++;
    end
    if (t == 200) fail_count++;
    repeat (2) @(negedge i_sys_clk);
  endtask : run

  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      close_out();
    end
  end

  // Mirrors lag one cycle, so the register file is compared one cycle after the done pulse.
  always @(negedge i_sys_clk) begin
    if (done_d) check("regs", exp_q.size() ? exp_q.pop_front() : 'x, seen);
    if (done_d) check("index regs", {`BLG_RST_WORD, `BLG_RST_WORD}, {o_index_reg_one, o_index_reg_two});
    done_d = (o_done === 1'b1);
    if (o_mem_rd === 1'b1) begin
      if (rd_len == 0) check("read addr", rd_q.size() ? rd_q.pop_front() : 'x, o_mem_addr);
      rd_len++;
    end else if (rd_len > 0) begin
      check("read len", `BLG_T_MEM, rd_len);
      rd_len = 0;
    end
    if (o_mem_wr === 1'b1) begin
      if (wr_len == 0) check("write", wr_q.size() ? wr_q.pop_front() : 'x, {o_mem_addr, o_mem_wdata});
      wr_len++;
    end else if (wr_len > 0) begin
      check("write len", `BLG_T_MEM, wr_len);
      wr_len = 0;
    end
  end

  initial begin
    int         r, s;
    logic [7:0] n, d;
    logic [15:0] a;
    r = $urandom(32'h1375a03a);
    foreach (rf[i]) rf[i] = 8'h00;
    repeat (2) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    i_reset_n = 1'b1;
    check("reset regs", pack_rf(), seen);
    foreach (sel[i]) begin
      n = 8'($urandom);
      rf[sel[i]] = n;
      exp_q.push_back(pack_rf());
      run('{{2'b00, 3'(sel[i]), 3'b110}, n, 8'h00, 8'h00}, '{4, 3, 0, 0}, 2);
    end
    foreach (sel[i]) begin
      s = sel[$urandom % 7];
      rf[sel[i]] = rf[s];
      exp_q.push_back(pack_rf());
      run('{{2'b01, 3'(sel[i]), 3'(s)}, 8'h00, 8'h00, 8'h00}, '{4, 0, 0, 0}, 1);
    end
    foreach (sel[i]) begin
      wr_q.push_back({rf[4], rf[5], rf[sel[i]]});
      exp_q.push_back(pack_rf());
      run('{{5'b01110, 3'(sel[i])}, 8'h00, 8'h00, 8'h00}, '{4, 0, 0, 0}, 1);
    end
    foreach (sel[i]) begin
      a = {rf[4], rf[5]};
      n = 8'($urandom);
      mdl.mem[a] = n;
      rd_q.push_back(a);
      rf[sel[i]] = n;
      exp_q.push_back(pack_rf());
      run('{{2'b01, 3'(sel[i]), 3'b110}, 8'h00, 8'h00, 8'h00}, '{4, 0, 0, 0}, 1);
    end
    // Index registers reset to zero, so the address is the sign-extended displacement alone.
    for (int k = 0; k < 6; k++) begin
      d = (k % 3 == 0) ? 8'h7f : (k % 3 == 1) ? 8'h80 : 8'($urandom);
      a = {{8{d[7]}}, d};
      s = sel[$urandom % 7];
      n = 8'($urandom);
      mdl.mem[a] = n;
      rd_q.push_back(a);
      rf[s] = n;
      exp_q.push_back(pack_rf());
      run('{k < 3 ? `BLG_PFX_ONE : `BLG_PFX_TWO, {2'b01, 3'(s), 3'b110}, d, 8'h00},
          '{4, 4, 3, 0}, 3);
    end
    i_start = 1'b1;
    fetch = 8'h3e;
    repeat (3) @(negedge i_sys_clk);
    i_start = 1'b0;
    i_reset_n = 1'b0;
    foreach (rf[i]) rf[i] = 8'h00;
    repeat (2) @(negedge i_sys_clk);
    i_reset_n = 1'b1;
    check("mid reset regs", pack_rf(), seen);
    check("mid reset busy", 1'b0, o_busy);
    rf[7] = 8'h5a;
    exp_q.push_back(pack_rf());
    run('{8'h3e, 8'h5a, 8'h00, 8'h00}, '{4, 3, 0, 0}, 2);
    close_out();
  end
endmodule : tb
